// file: mgmt_host.sv
// mgmt_host: station management model issuing register strobes.
// Assumes one-cycle strobes on ref_clk and a registered read answer.
`timescale 1ns/10ps
`default_nettype none
module mgmt_host (
    // clock and strap seen by the host
    input  wire logic                            ref_clk,
    input  wire logic                            autoneg_strap,
    // register port
    input  wire logic [mode_ctl_pkg::DATA_W-1:0] reg_rdata,
    output logic      [4:0]                      reg_addr,
    output logic                                 reg_wr,
    output logic                                 reg_rd,
    output logic      [mode_ctl_pkg::DATA_W-1:0] reg_wdata
);
    // idle bus at time zero
    initial begin
        reg_addr = 5'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end
    // one write strobe; released data shows the inverse
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= autoneg_strap ? (d & 16'hDFFF) : d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    // one read strobe; data taken after the answering edge
    task automatic rd(input logic [4:0] a, output logic [15:0] q);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask : rd
endmodule : mgmt_host
`default_nettype wire

// file: mode_ctl_checker.sv
// mode_ctl_checker: port-level assertions for the mode control register.
// Assumes it is bound onto phy_mode_control_register, one clock ref_clk.
`timescale 1ns/10ps
`default_nettype none
module mode_ctl_checker (
    // clock, reset and management port
    input wire logic                              ref_clk, rstn,
    input wire logic                              reg_wr, reg_rd,
    input wire logic [4:0]                        reg_addr,
    input wire logic [mode_ctl_pkg::DATA_W-1:0]   reg_wdata, reg_rdata,
    // status inputs
    input wire logic                              local_loopback,
    input wire logic                              full_duplex_ctl,
    input wire logic                              repeater_mode,
    input wire logic                              rx_err_full_evt,
    // control outputs
    input wire logic                              link10_forced,
    input wire logic                              link100_ignored,
    input wire logic                              jabber_off, seven_wire_on,
    input wire logic                              activity_led_rx_only,
    input wire logic                              far_fault_off,
    input wire logic                              rx_error_count_off,
    input wire logic                              scrambler_on,
    input wire logic                              coding_sublayer_bypass,
    input wire logic                              fiber_mode_select
);
    import mode_ctl_pkg::*;
    logic [1:0] up;   // edges since reset release, saturating
    logic       wr15; // write aimed at this register
    logic       rd15; // read aimed at this register
    assign wr15 = reg_wr && reg_addr == MODE_CTL_ADDR;
    assign rd15 = reg_rd && reg_addr == MODE_CTL_ADDR;
    // ========================================
    // settle counter, hides the strap capture cycles
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) up <= 2'h0;
        else if (up != 2'h3) up <= up + 2'h1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // ========================================
    // a taken write shows on its output two edges later
    property p_wr(int b, logic o);
        (wr15 && up != 2'h0 ##1 !wr15) |-> ##1 o == $past(reg_wdata[b], 2);
    endproperty
    a_link100_write: assert property (p_wr(13, link100_ignored))
        else $error("link100 output does not follow write");
    a_jabber_write: assert property (p_wr(12, jabber_off))
        else $error("jabber output does not follow write");
    a_rxe_off_write: assert property (p_wr(5, rx_error_count_off))
        else $error("error counter output does not follow write");
    a_loop_forces_link: assert property
        (local_loopback && up == 2'h3 |=> link10_forced)
        else $error("loopback did not force 10 Mb link");
    a_bypass_blocks_seven: assert property
        (up == 2'h3 && coding_sublayer_bypass |-> !seven_wire_on)
        else $error("seven-line mode active under bypass");
    a_duplex_blocks_led: assert property
        ((full_duplex_ctl || repeater_mode) && up == 2'h3
         |=> !activity_led_rx_only)
        else $error("activity bit acted in full duplex or repeater");
    a_fiber_off_fef: assert property
        (up == 2'h3 && !fiber_mode_select |-> far_fault_off)
        else $error("far-end-fault active outside fiber");
    a_fiber_no_scram: assert property
        (up == 2'h3 && fiber_mode_select |-> !scrambler_on)
        else $error("scrambler on in fiber mode");
    a_full_flag_set: assert property
        (rx_err_full_evt ##1 !rd15 ##1 (rd15 && !rx_err_full_evt)
         |=> reg_rdata[6])
        else $error("counter-full flag not reported");
    a_full_flag_clear: assert property
        ((rd15 && !rx_err_full_evt) ##1 !rx_err_full_evt
         ##1 (rd15 && !rx_err_full_evt) |=> !reg_rdata[6])
        else $error("counter-full flag not cleared by read");
    a_reserved_zero: assert property (rd15 |=> !reg_rdata[15])
        else $error("reserved bit read as one");
    // ========================================
    // main scenarios reached
    c_write: cover property (wr15 && up != 2'h0);
    c_flag: cover property (rx_err_full_evt);
    c_loop: cover property (local_loopback && link10_forced);
endmodule : mode_ctl_checker
bind phy_mode_control_register mode_ctl_checker i_chk (.ref_clk, .rstn,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .local_loopback,
    .full_duplex_ctl, .repeater_mode, .rx_err_full_evt, .link10_forced,
    .link100_ignored, .jabber_off, .seven_wire_on, .activity_led_rx_only,
    .far_fault_off, .rx_error_count_off, .scrambler_on,
    .coding_sublayer_bypass, .fiber_mode_select);
`default_nettype wire

// file: mode_ctl_pkg.sv
// mode_ctl_pkg: register index, field positions and reset values of the
// mode control register. Assumes a 16-bit management register port.
package mode_ctl_pkg;
    // ========================================
    // register map
    localparam logic [4:0] MODE_CTL_ADDR = 5'h15; // register index
    localparam int unsigned DATA_W = 16;          // register width
    // ========================================
    // field positions
    localparam int unsigned B_RSVD      = 15;
    localparam int unsigned B_LINK10    = 14;
    localparam int unsigned B_LINK100   = 13;
    localparam int unsigned B_JABOFF    = 12;
    localparam int unsigned B_SEVENWIRE = 11;
    localparam int unsigned B_ALED      = 10;
    localparam int unsigned B_LEDSEL    = 9;
    localparam int unsigned B_FEFOFF    = 8;
    localparam int unsigned B_FEFSEND   = 7;
    localparam int unsigned B_RXEFULL   = 6;
    localparam int unsigned B_RXEOFF    = 5;
    localparam int unsigned B_WDTOFF    = 4;
    localparam int unsigned B_RLOOP     = 3;
    localparam int unsigned B_SCRM      = 2;
    localparam int unsigned B_BYPASS    = 1;
    localparam int unsigned B_FIBER     = 0;
    // ========================================
    // reset values of plain read/write bits
    localparam logic [DATA_W-1:0] RW_RESET = 16'h0000;
    // bits software may write (reserved and read-only flag excluded)
    localparam logic [DATA_W-1:0] RW_MASK  = 16'h7FBF;
    // ========================================
    // strap capture sequence
    typedef enum logic [1:0] {
        ST_CAPTURE = 2'h1,   // first cycle after reset release
        ST_RUN     = 2'h2    // normal operation
    } strap_state_t;
endpackage : mode_ctl_pkg

// file: mode_regs_if.sv
// mode_regs_if: carries the held register image from the storage module.
// Assumes a single clock domain.
`timescale 1ns/10ps
`default_nettype none
interface mode_regs_if;
    import mode_ctl_pkg::*;
    logic [DATA_W-1:0] image;    // stored control bits
    logic              full_flg; // sticky counter-full flag
    modport store (output image, output full_flg);
    modport use_side (input image, input full_flg);
endinterface : mode_regs_if
`default_nettype wire

// file: mode_store.sv
// mode_store: storage of the mode control bits and the sticky full flag.
// Assumes writes, reads and straps come synchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none
module mode_store (
    // clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         rstn,
    // write and read strobes
    input  wire logic                         wr_en,
    input  wire logic [mode_ctl_pkg::DATA_W-1:0] wr_data,
    input  wire logic                         rd_en,
    // strap load, one cycle after reset release
    input  wire logic                         strap_load,
    input  wire logic [mode_ctl_pkg::DATA_W-1:0] strap_image,
    // counter-full event
    input  wire logic                         rx_err_full_evt,
    // held image
    mode_regs_if.store                        regs
);
    import mode_ctl_pkg::*;

    logic [DATA_W-1:0] image;    // control bits
    logic              full_flg; // sticky full flag

    // ========================================
    // control bits: strap load, then software writes
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            image <= RW_RESET;
        end else if (strap_load) begin
            image <= strap_image;
        end else if (wr_en) begin
            image <= wr_data & RW_MASK;
        end
    end

    // sticky full flag: an event wins over the clearing read
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            full_flg <= 1'b0;
        end else if (rx_err_full_evt) begin
            full_flg <= 1'b1;
        end else if (rd_en) begin
            full_flg <= 1'b0;
        end
    end

    assign regs.image    = image;
    assign regs.full_flg = full_flg;
endmodule : mode_store
`default_nettype wire

// file: phy_mode_control_register.sv
// phy_mode_control_register: mode control register of a 10/100 PHY and
// the control levels it steers. Assumes the management frame logic gives
// one-cycle read and write strobes for this register, straps are stable
// around reset release, and all inputs are synchronous to ref_clk.
// Functional notes
// - force 10 Mb link up; also in loopback
// - bit 13 ignores 100 Mb link state
// - bit 12 switches jabber detection off
// - bit 11 selects seven-line MAC interface
// - seven-line selection ignored under coding bypass
// - activity LED receive only when set
// - activity bit ignored full duplex or repeater
// - LED scheme bit, reset from rx strap
// - far-end-fault off bit, fiber only, strapped
// - bit 7 forces far-end-fault pattern
// - counter-full flag, read-only, cleared by read
// - bit 5 stops the receive-error counter
// - bit 4 stops descrambler watchdog
// - bit 3 enables remote loopback
// - scrambler bit, strapped, forced 0 in fiber
// - coding sublayer bypass, reset from strap
// - fiber select, reset from strap
`timescale 1ns/10ps
`default_nettype none
module phy_mode_control_register (
    // clock and reset
    input  wire logic                            ref_clk,
    input  wire logic                            rstn,
    // management register port
    input  wire logic [4:0]                      reg_addr,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    input  wire logic [mode_ctl_pkg::DATA_W-1:0] reg_wdata,
    output logic      [mode_ctl_pkg::DATA_W-1:0] reg_rdata,
    // strap pins
    input  wire logic                            rx_indicator_strap,
    input  wire logic [2:0]                      technology_strap,
    input  wire logic                            autoneg_strap,
    input  wire logic                            scrambler_strap,
    input  wire logic                            coding_sublayer_bypass_strap,
    input  wire logic                            fiber_mode_select_strap,
    // status from the rest of the device
    input  wire logic                            local_loopback,
    input  wire logic                            full_duplex_ctl,
    input  wire logic                            repeater_mode,
    input  wire logic                            rx_err_full_evt,
    // control levels to the datapath
    output logic                                 link10_forced,
    output logic                                 link100_ignored,
    output logic                                 jabber_off,
    output logic                                 seven_wire_on,
    output logic                                 activity_led_rx_only,
    output logic                                 led_scheme_select,
    output logic                                 far_fault_off,
    output logic                                 far_fault_send_force,
    output logic                                 rx_error_count_off,
    output logic                                 descrambler_watchdog_off,
    output logic                                 remote_loopback_on,
    output logic                                 scrambler_on,
    output logic                                 coding_sublayer_bypass,
    output logic                                 fiber_mode_select
);
    import mode_ctl_pkg::*;

    // ========================================
    // address decode
    function automatic logic hit(input logic [4:0] a);
        hit = (a == MODE_CTL_ADDR);
    endfunction : hit

    strap_state_t      st;          // strap capture state
    logic              strap_load;  // one-cycle strap capture
    logic [DATA_W-1:0] strap_image; // strapped reset image
    logic [DATA_W-1:0] img;         // held control bits
    logic              full_flg;    // sticky full flag
    logic [DATA_W-1:0] next_rdata;  // read value
    logic              wr_hit;      // write to this register
    logic              rd_hit;      // read of this register
    logic              fef_dflt;    // far-end-fault default

    mode_regs_if regs ();

    assign wr_hit = reg_wr & hit(reg_addr) & (st == ST_RUN);
    assign rd_hit = reg_rd & hit(reg_addr);

    // ========================================
    // strap capture: take pins one cycle after reset release
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st <= ST_CAPTURE;
        end else begin
            unique case (st)
                ST_CAPTURE: st <= ST_RUN;
                ST_RUN:     st <= ST_RUN;
                default:    st <= ST_CAPTURE;
            endcase
        end
    end

    assign strap_load = (st == ST_CAPTURE);

    // far-end-fault on by default only for fiber without autoneg;
    // and only while the technology straps are not all zero
    assign fef_dflt = ~(fiber_mode_select_strap & ~autoneg_strap
                        & (technology_strap != 3'h0));

    // strapped reset image
    always_comb begin
        strap_image              = RW_RESET;
        strap_image[B_LEDSEL]    = rx_indicator_strap;
        strap_image[B_FEFOFF]    = fef_dflt;
        strap_image[B_SCRM]      = scrambler_strap
                                   & ~fiber_mode_select_strap;
        strap_image[B_BYPASS]    = coding_sublayer_bypass_strap;
        strap_image[B_FIBER]     = fiber_mode_select_strap;
    end

    // ========================================
    // storage
    mode_store u_store (
        .ref_clk         (ref_clk),
        .rstn            (rstn),
        .wr_en           (wr_hit),
        .wr_data         (reg_wdata),
        .rd_en           (rd_hit),
        .strap_load      (strap_load),
        .strap_image     (strap_image),
        .rx_err_full_evt (rx_err_full_evt),
        .regs            (regs.store)
    );

    assign img      = regs.image;
    assign full_flg = regs.full_flg;

    // ========================================
    // read value: reserved zero, scrambler shown forced in fiber
    always_comb begin
        next_rdata            = img;
        next_rdata[B_RSVD]    = 1'b0;
        next_rdata[B_RXEFULL] = full_flg;
        next_rdata[B_SCRM]    = img[B_SCRM] & ~img[B_FIBER];
    end

    // read data register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else if (rd_hit) begin
            reg_rdata <= next_rdata;
        end
    end

    // ========================================
    // link control levels
    // every control level is a flop of its own, so each output
    // settles exactly one edge after its stored bit changes and a
    // slow decode in one path cannot skew the others

    // 10 Mb link forced up, also during local loopback
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            link10_forced <= 1'b0;
        end else begin
            link10_forced <= img[B_LINK10] | local_loopback;
        end
    end

    // 100 Mb link state ignored; keeping autoneg off while this
    // is set is left to the managing side
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            link100_ignored <= 1'b0;
        end else begin
            link100_ignored <= img[B_LINK100];
        end
    end

    // jabber detection switched off
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            jabber_off <= 1'b0;
        end else begin
            jabber_off <= img[B_JABOFF];
        end
    end

    // ========================================
    // interface and indicator levels

    // seven-line interface, only while coding bypass is off
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            seven_wire_on <= 1'b0;
        end else begin
            seven_wire_on <= img[B_SEVENWIRE] & ~img[B_BYPASS];
        end
    end

    // activity indicator on receive only; the bit is ignored in
    // full duplex and in repeater mode
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            activity_led_rx_only <= 1'b0;
        end else begin
            activity_led_rx_only <= img[B_ALED] & ~full_duplex_ctl
                                    & ~repeater_mode;
        end
    end

    // indicator scheme choice
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            led_scheme_select <= 1'b0;
        end else begin
            led_scheme_select <= img[B_LEDSEL];
        end
    end

    // ========================================
    // fiber and far-end-fault levels

    // far-end-fault off; the bit means nothing outside fiber, so
    // the function is held off there
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            far_fault_off <= 1'b0;
        end else begin
            far_fault_off <= img[B_FEFOFF] | ~img[B_FIBER];
        end
    end

    // far-end-fault pattern sent whatever the link state
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            far_fault_send_force <= 1'b0;
        end else begin
            far_fault_send_force <= img[B_FEFSEND];
        end
    end

    // scrambler; held off in fiber whatever the stored bit says,
    // so a late fiber select never leaves scrambling running
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            scrambler_on <= 1'b0;
        end else begin
            scrambler_on <= img[B_SCRM] & ~img[B_FIBER];
        end
    end

    // coding sublayer bypass
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            coding_sublayer_bypass <= 1'b0;
        end else begin
            coding_sublayer_bypass <= img[B_BYPASS];
        end
    end

    // fiber operation
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fiber_mode_select <= 1'b0;
        end else begin
            fiber_mode_select <= img[B_FIBER];
        end
    end

    // ========================================
    // receive path levels
    // plain copies of stored bits, no side conditions

    // receive-error counter stopped
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rx_error_count_off <= 1'b0;
        end else begin
            rx_error_count_off <= img[B_RXEOFF];
        end
    end

    // descrambler watchdog stopped
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            descrambler_watchdog_off <= 1'b0;
        end else begin
            descrambler_watchdog_off <= img[B_WDTOFF];
        end
    end

    // remote loopback at the media side
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            remote_loopback_on <= 1'b0;
        end else begin
            remote_loopback_on <= img[B_RLOOP];
        end
    end
endmodule : phy_mode_control_register
`default_nettype wire

// file: testbench.sv
// testbench: directed scenarios for the mode control register.
// Assumes mode_ctl_pkg, mgmt_host and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
    $display("ERROR %0t got %h expected %h", $time, a, e); end end
module testbench;
    import mode_ctl_pkg::*;
    logic        ref_clk, rstn, rx_indicator_strap, autoneg_strap;
    logic        scrambler_strap, coding_sublayer_bypass_strap;
    logic        fiber_mode_select_strap, local_loopback, full_duplex_ctl;
    logic        repeater_mode, rx_err_full_evt, reg_wr, reg_rd;
    logic [2:0]  technology_strap;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, q;
    logic        link10_forced, link100_ignored, jabber_off, seven_wire_on;
    logic        activity_led_rx_only, led_scheme_select, far_fault_off;
    logic        far_fault_send_force, rx_error_count_off, scrambler_on;
    logic        descrambler_watchdog_off, remote_loopback_on;
    logic        coding_sublayer_bypass, fiber_mode_select;
    int          errors, num_checks;
    phy_mode_control_register i_dut (.ref_clk, .rstn, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata, .reg_rdata, .rx_indicator_strap,
        .technology_strap, .autoneg_strap, .scrambler_strap,
        .coding_sublayer_bypass_strap, .fiber_mode_select_strap,
        .local_loopback, .full_duplex_ctl, .repeater_mode, .rx_err_full_evt,
        .link10_forced, .link100_ignored, .jabber_off, .seven_wire_on,
        .activity_led_rx_only, .led_scheme_select, .far_fault_off,
        .far_fault_send_force, .rx_error_count_off, .descrambler_watchdog_off,
        .remote_loopback_on, .scrambler_on, .coding_sublayer_bypass,
        .fiber_mode_select);
    mgmt_host i_host (.ref_clk, .autoneg_strap, .reg_rdata, .reg_addr,
        .reg_wr, .reg_rd, .reg_wdata);
    // ========================================
    // clock, 25 ns period
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // verdict and end of run
    task complete_run;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    // let registered outputs land
    task settle;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : settle
    // reset 16 cycles with straps {rx, tech, aneg, scr, bypass, fiber}
    task do_reset(input logic [7:0] s);
        @(posedge ref_clk) rstn <= 1'b0;
        {rx_indicator_strap, technology_strap, autoneg_strap,
         scrambler_strap, coding_sublayer_bypass_strap,
         fiber_mode_select_strap} <= s;
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        settle();
    endtask : do_reset
    // ========================================
    // strapped defaults for copper and fiber
    task t_straps;
        do_reset(8'b1_001_1_1_1_0);
        i_host.rd(MODE_CTL_ADDR, q);
        `CHK(q, 16'h0306)
        `CHK({led_scheme_select, coding_sublayer_bypass, scrambler_on}, 3'h7)
        do_reset(8'b0_001_0_1_0_1);
        i_host.rd(MODE_CTL_ADDR, q);
        `CHK(q, 16'h0001)
        `CHK({fiber_mode_select, scrambler_on, far_fault_off}, 3'h4)
    endtask : t_straps
    // all ones, then seven-line and activity cases, unmapped access
    task t_write;
        i_host.wr(MODE_CTL_ADDR, 16'hFFFF);
        settle();
        i_host.rd(MODE_CTL_ADDR, q);
        `CHK(q, 16'h7FBB)
        `CHK({link10_forced, link100_ignored, jabber_off, far_fault_send_force, rx_error_count_off, descrambler_watchdog_off, remote_loopback_on, far_fault_off}, 8'hFF)
        `CHK({seven_wire_on, scrambler_on, activity_led_rx_only}, 3'h1)
        i_host.wr(MODE_CTL_ADDR, 16'h0C04);
        i_host.wr(5'h14, 16'hFFFF);
        settle();
        `CHK({seven_wire_on, scrambler_on, activity_led_rx_only}, 3'h7)
        `CHK({far_fault_off, remote_loopback_on, jabber_off}, 3'h4)
        i_host.rd(5'h14, q);
        i_host.rd(MODE_CTL_ADDR, q);
        `CHK(q, 16'h0C04)
        @(posedge ref_clk) full_duplex_ctl <= 1'b1;
        settle();
        `CHK(activity_led_rx_only, 1'b0)
        @(posedge ref_clk) full_duplex_ctl <= 1'b0;
        repeater_mode <= 1'b1;
        settle();
        `CHK(activity_led_rx_only, 1'b0)
        @(posedge ref_clk) repeater_mode <= 1'b0;
    endtask : t_write
    // loopback forces the 10 Mb link
    task t_loopback;
        i_host.wr(MODE_CTL_ADDR, 16'h0000);
        settle();
        `CHK({link10_forced, descrambler_watchdog_off}, 2'h0)
        @(posedge ref_clk) local_loopback <= 1'b1;
        settle();
        `CHK(link10_forced, 1'b1)
        @(posedge ref_clk) local_loopback <= 1'b0;
    endtask : t_loopback
    // counter-full flag set by event, cleared by read
    task t_flag;
        @(posedge ref_clk) rx_err_full_evt <= 1'b1;
        @(posedge ref_clk) rx_err_full_evt <= 1'b0;
        i_host.rd(MODE_CTL_ADDR, q);
        `CHK(q[6], 1'b1)
        i_host.rd(MODE_CTL_ADDR, q);
        `CHK(q[6], 1'b0)
        // event and clearing read at one edge: the set wins
        fork
            i_host.rd(MODE_CTL_ADDR, q);
            begin
                @(posedge ref_clk) rx_err_full_evt <= 1'b1;
                @(posedge ref_clk) rx_err_full_evt <= 1'b0;
            end
        join
        `CHK(q[6], 1'b0)
        i_host.rd(MODE_CTL_ADDR, q);
        `CHK(q[6], 1'b1)
        i_host.rd(MODE_CTL_ADDR, q);
        `CHK(q[6], 1'b0)
    endtask : t_flag
    // ========================================
    // main sequence
    initial begin
        {rstn, rx_indicator_strap, technology_strap, autoneg_strap} = 6'h00;
        {scrambler_strap, coding_sublayer_bypass_strap} = 2'h0;
        {fiber_mode_select_strap, local_loopback, full_duplex_ctl} = 3'h0;
        {repeater_mode, rx_err_full_evt} = 2'h0;
        errors = 0;
        num_checks = 0;
        t_straps();
        t_write();
        t_loopback();
        t_flag();
        complete_run();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        $display("ERROR %0t run too long", $time);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
